// ===== lddr_port.sv
/*
 * Double-data-rate sample input port. Oversamples the source clock,
 * data bus and frame marker with the 50 MHz system clock and captures
 * one word on each data-clock edge. Assumes the source clock is well
 * below a quarter of the system clock and data is stable around edges.
 * Limitation: a capture lands three system clocks after the pin edge,
 * give or take one clock of phase, so downstream logic must not rely
 * on a fixed latency to the source clock.
 */
// Summary of operation
// - Capture the 16-bit bus on both data-clock edges, two words per period.
// - Default order: input bit 15 is MSB, bit 0 is LSB.
// - Bus-reverse bit set swaps bit order of the captured word.
// - Marker sampled on rising edge resets pointer and acts as sync.
// - Marker going high between rising-edge samples marks the first word of a frame.
// - External-reference bit 1 disables internal reference, pin becomes input.
`timescale 1ns/1ps
module lddr_port
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic sample_strobe_clk_pos,
    input wire logic frame_marker_pos,
    input wire logic [lddr_pkg::LDDR_DATA_W-1:0] sample_bus,
    input wire logic rev_bus_order,
    input wire logic ext_ref_select,
    input wire logic reference_io_pin_in,
    output logic reference_io_pin_out,
    output logic reference_io_pin_oe,
    output logic internal_ref_enable,
    output logic [lddr_pkg::LDDR_DATA_W-1:0] word_out,
    output logic word_valid,
    output logic word_rising,
    output logic pointer_reset,
    output logic sync_pulse,
    output logic frame_start,
    output logic block_parity,
    output logic block_parity_valid
);
    import lddr_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Output bit i takes input bit WIDTH-1-i; used by the bus-reverse mode
    function automatic logic [LDDR_DATA_W-1:0] reverse_bits(input logic [LDDR_DATA_W-1:0] v);
        logic [LDDR_DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < LDDR_DATA_W; i++)
            r[i] = v[LDDR_DATA_W-1-i];
        return r;
    endfunction : reverse_bits

    // ************************************************************
    // Synchronisers
    // ************************************************************
    lddr_pins_t pins_raw;
    lddr_pins_t pins_sync;
    logic cfg_rev_sync;
    logic cfg_rev_meta_reg;
    logic cfg_rev_reg;
    logic clk_prev_reg;

    // Clock level, marker and data share one synchroniser so that all
    // three reach the edge detector after the same number of stages
    assign pins_raw = '{clk_level: sample_strobe_clk_pos,
                        marker: frame_marker_pos,
                        data: sample_bus};

    lddr_sync #(.WIDTH($bits(lddr_pins_t))) u_sync
    (
        .clock(clock),
        .resetn(resetn),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // Configuration bit is static but still crossed for safety
    // against a change while words are arriving
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cfg_rev_meta_reg <= 1'b0;
            cfg_rev_reg <= 1'b0;
        end
        else
        begin
            cfg_rev_meta_reg <= rev_bus_order;
            cfg_rev_reg <= cfg_rev_meta_reg;
        end
    end
    assign cfg_rev_sync = cfg_rev_reg;

    // ************************************************************
    // Edge detection and word shaping
    // ************************************************************
    logic edge_rise;
    logic edge_fall;
    logic [LDDR_DATA_W-1:0] word_shaped;
    lddr_sample_t sample_next;

    // Previous level resets low, the idle level of the source clock,
    // so no false edge appears just after reset
    // both clock edges
    assign edge_rise = pins_sync.clk_level && !clk_prev_reg;
    assign edge_fall = !pins_sync.clk_level && clk_prev_reg;
    assign word_shaped = cfg_rev_sync ? reverse_bits(pins_sync.data) : pins_sync.data;
    assign sample_next = '{word: word_shaped, marker: pins_sync.marker, rising: edge_rise};

    // ************************************************************
    // Capture registers
    // ************************************************************
    logic marker_rise_prev_reg;
    logic capture_any;
    logic marker_at_rise;
    logic frame_begin;

    // One capture per detected edge of either polarity
    assign capture_any = edge_rise || edge_fall;
    assign marker_at_rise = edge_rise && sample_next.marker;
    // only a low-to-high change of the rising sample opens a frame
    // so a marker held high over several periods gives a single start
    assign frame_begin = marker_at_rise && !marker_rise_prev_reg;

    // Data and marker are synchronised together with the clock level,
    // so edge alignment from the source keeps them consistent.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            clk_prev_reg <= 1'b0;
            word_out <= LDDR_DATA_RESET;
            word_valid <= 1'b0;
            word_rising <= 1'b0;
        end
        else
        begin
            clk_prev_reg <= pins_sync.clk_level;
            word_valid <= capture_any;
            word_rising <= edge_rise;
            if (capture_any)
                word_out <= sample_next.word;
        end
    end

    // ************************************************************
    // Marker handling
    // ************************************************************
    // Rising-edge marker: pointer reset, sync and frame start pulses.
    // The pulses last one system clock; a consumer on a slower clock
    // must stretch them itself.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            marker_rise_prev_reg <= 1'b0;
            pointer_reset <= 1'b0;
            sync_pulse <= 1'b0;
            frame_start <= 1'b0;
        end
        else
        begin
            pointer_reset <= marker_at_rise;
            sync_pulse <= marker_at_rise;
            frame_start <= frame_begin;
            if (edge_rise)
                marker_rise_prev_reg <= sample_next.marker;
        end
    end

    // Falling-edge marker: parity bit held until the next falling edge
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            block_parity <= 1'b0;
            block_parity_valid <= 1'b0;
        end
        else
        begin
            block_parity_valid <= edge_fall;
            if (edge_fall)
                block_parity <= sample_next.marker;
        end
    end

    // ************************************************************
    // Reference pin control
    // ************************************************************
    logic ref_internal;

    // 0 keeps the internal reference on and drives the pin
    // 1 turns it off and hands the pin to an external source, whose
    // level is analog, so the pin's input side is not read here
    assign ref_internal = !ext_ref_select;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            reference_io_pin_oe <= LDDR_REF_RESET;
            reference_io_pin_out <= LDDR_REF_RESET;
            internal_ref_enable <= LDDR_REF_RESET;
        end
        else
        begin
            reference_io_pin_oe <= ref_internal;
            reference_io_pin_out <= ref_internal;
            internal_ref_enable <= ref_internal;
        end
    end

endmodule : lddr_port

// ===== lddr_pkg.sv
/*
 * Package for the double-data-rate sample input port: bus widths,
 * synchroniser depth and the packed carriers passed between modules.
 * Assumes a single 50 MHz system clock domain.
 */
package lddr_pkg;

    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int LDDR_DATA_W = 16;
    localparam int LDDR_SYNC_STAGES = 2;
    localparam logic [15:0] LDDR_DATA_RESET = 16'h0000;
    // Reference pin comes out of reset driving the internal reference
    localparam logic LDDR_REF_RESET = 1'b1;

    // ************************************************************
    // Carriers
    // ************************************************************
    // One captured word with its frame marker sample
    typedef struct packed {
        logic [15:0] word;
        logic marker;
        logic rising;
    } lddr_sample_t;

    // Input pins after the two-flop synchroniser
    typedef struct packed {
        logic clk_level;
        logic marker;
        logic [15:0] data;
    } lddr_pins_t;

endpackage : lddr_pkg

// ===== lddr_sync.sv
/*
 * Two-flop synchroniser for the port's incoming pins (data clock,
 * marker and data bus). Assumes the pins are asynchronous to clock.
 */
`timescale 1ns/1ps
module lddr_sync
#(
    parameter int WIDTH = 18
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import lddr_pkg::*;

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule : lddr_sync

// ===== lddr_chk_sva.sv
/* Checker on the sample port outputs.
   Assumes it is bound onto lddr_port. */
`timescale 1ns/1ps
module lddr_chk
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ext_ref_select,
    input wire logic reference_io_pin_oe,
    input wire logic internal_ref_enable,
    input wire logic word_valid,
    input wire logic word_rising,
    input wire logic pointer_reset,
    input wire logic sync_pulse,
    input wire logic frame_start,
    input wire logic block_parity_valid
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_SYNC: assert property (sync_pulse == pointer_reset) else $error("sync");
    AST_PTR: assert property (pointer_reset |-> word_valid && word_rising)
        else $error("ptr");
    AST_PAR: assert property (block_parity_valid |-> word_valid && !word_rising)
        else $error("par");
    AST_PAIR: assert property (word_valid && !word_rising |-> block_parity_valid)
        else $error("pair");
    AST_FRM: assert property (frame_start |-> pointer_reset) else $error("frm");
    // Half a link period is four clocks, so captures are spaced
    AST_GAP: assert property (word_valid |=> !word_valid [*3]) else $error("gap");
    AST_REF: assert property ($past(resetn) |->
        internal_ref_enable == !$past(ext_ref_select)) else $error("ref");
    AST_OE: assert property ($past(resetn) |->
        reference_io_pin_oe == !$past(ext_ref_select)) else $error("oe");
endmodule : lddr_chk
bind lddr_port lddr_chk lddr_chk_inst (.*);

// ===== lddr_src.sv
/* Behavioural source: data clock, frame marker and data bus.
   Assumes the caller spaces its periods. */
`timescale 1ns/1ps
module lddr_src
(
    output logic strobe,
    output logic marker,
    output logic [15:0] data
);
    // Clock stands low between periods
    initial {strobe, marker, data} = 18'h00000;
    // Bit 15 is MSB, marker moves with data
    task automatic send(input logic [15:0] a, b, input logic ma, mb);
        {marker, data} = {ma, a};
        #40 strobe = 1'h1;
        #40 {marker, data} = {mb, b};
        #40 strobe = 1'h0;
        // Released pins show the inverse, so a stale word cannot pass
        #40 {marker, data} = ~{mb, b};
    endtask : send
endmodule : lddr_src

// ===== tb_lddr_port.sv
/* Bench for lddr_port fed by lddr_src.
   Assumes a 20 ns clock and a 160 ns link clock. */
`timescale 1ns/1ps
module tb_lddr_port;
    import lddr_pkg::*;
    typedef struct packed {logic [15:0] a, b, xa, xb; logic ma, mb, rv, xf;} lddr_row_t;
    logic clock = 1'h0;
    logic resetn = 1'h0;
    logic rev_bus_order = 1'h0;
    logic ext_ref_select = 1'h0;
    logic reference_io_pin_in = 1'h0;
    logic sample_strobe_clk_pos, frame_marker_pos, reference_io_pin_out, reference_io_pin_oe;
    logic internal_ref_enable, word_valid, word_rising, pointer_reset, sync_pulse, frame_start;
    logic block_parity, block_parity_valid, rp, rs, rf, fp;
    logic [15:0] sample_bus, word_out, rw, fw;
    int fail_count = 0;
    int cmp_count = 0;
    int nw = 0;
    // Sent words, then expected words, markers, order and frame flag
    lddr_row_t rows [4] = '{
        '{16'h8001, 16'h0001, 16'h8001, 16'h0001, 1'h1, 1'h0, 1'h0, 1'h1},
        '{16'h1234, 16'hFFFE, 16'h1234, 16'hFFFE, 1'h1, 1'h1, 1'h0, 1'h0},
        '{16'h0001, 16'h00F0, 16'h8000, 16'h0F00, 1'h0, 1'h1, 1'h1, 1'h0},
        '{16'hA5C3, 16'h0001, 16'hC3A5, 16'h8000, 1'h1, 1'h0, 1'h1, 1'h1}};
    initial forever #10 clock = ~clock;
    lddr_src lddr_src_inst (.strobe(sample_strobe_clk_pos), .marker(frame_marker_pos),
        .data(sample_bus));
    lddr_port lddr_port_inst (.*);
    // Keep the latest word of each kind
    always @(posedge clock)
    begin
        nw <= nw + (word_valid === 1'h1);
        if (word_valid === 1'h1 && word_rising === 1'h1)
            {rw, rp, rs, rf} <= {word_out, pointer_reset, sync_pulse, frame_start};
        if (word_valid === 1'h1 && word_rising === 1'h0)
            {fw, fp} <= {word_out, block_parity};
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // Main sequence
    initial
    begin
        repeat (12) @(negedge clock);
        chk(16'(word_valid), 16'h0000);
        chk(16'({internal_ref_enable, reference_io_pin_oe}), 16'h0003);
        chk(16'(reference_io_pin_out), 16'h0001);
        resetn = 1'h1;
        foreach (rows[i])
        begin
            rev_bus_order = rows[i].rv;
            repeat (3) @(negedge clock);
            lddr_src_inst.send(rows[i].a, rows[i].b, rows[i].ma, rows[i].mb);
            repeat (6) @(negedge clock);
            chk(rw, rows[i].xa);
            chk(fw, rows[i].xb);
            chk(16'({rp, rs, fp, rf}), 16'({{2{rows[i].ma}}, rows[i].mb, rows[i].xf}));
        end
        chk(16'(nw), 16'h0008);
        // External reference, then reset forces internal
        ext_ref_select = 1'h1;
        repeat (2) @(negedge clock);
        chk(16'({internal_ref_enable, reference_io_pin_oe}), 16'h0000);
        chk(16'(reference_io_pin_out), 16'h0000);
        resetn = 1'h0;
        repeat (2) @(negedge clock);
        chk(16'({internal_ref_enable, reference_io_pin_oe}), 16'h0003);
        chk(16'({reference_io_pin_out, block_parity}), 16'h0002);
        complete_run();
    end
    // Watchdog, far beyond the two microseconds the tests need
    initial
    begin
        #20us;
        fail_count++;
        complete_run();
    end
endmodule : tb_lddr_port
